// File: torque_off_pkg.sv
// How it works
// - Internal diagnostics raise torque-off without inputs
// - Torque-off request asserts drive command at once
// - No encoder, no fly-start: ack waits for coast time
// - Fly-start: ack waits for restart delay
// - Short restart delay allows early fly-start ack
// - Encoder: ack waits for speed below limit
// - Auto ack uses the same gating
// - Indication output follows drive torque-off command
// - Brake control always leads to torque-off
// - Immediate torque-off on request, immediate estop, stop done
// - Positive delay: torque-off first, brake later
// - Encoder: brake early once below zero speed
// - Zero delay: torque-off and brake together
// - Negative delay: brake first, torque-off later
// - Missing relay feedback triggers configured reaction
// - Speed mode, delay not negative: both together
// - Speed mode, negative delay: brake, then torque-off
// - Faults, trips, passivation raise emergency stop
// - Limited-speed trip hit activates emergency stop
// - Emergency stop: immediate, ramp or time-monitored
// - Immediate emergency stop asserts torque-off at once
// - Requests accepted from either channel or fieldbus
package torque_off_pkg;
  // ****************************************
  // Timing
  // ****************************************
  localparam int CLK_PERIOD_NS = 8;
  localparam int MS_NS = 1000000;
  localparam int CYC_PER_MS = MS_NS / CLK_PERIOD_NS;
  localparam logic [3:0] FB_CHECK_CYC = 4'hF;
  // ****************************************
  // Register map
  // ****************************************
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_COAST = 8'h04;
  localparam logic [7:0] OFS_RESTART = 8'h08;
  localparam logic [7:0] OFS_BRAKE_DELAY = 8'h0C;
  localparam logic [7:0] OFS_ZERO_SPEED = 8'h10;
  localparam logic [7:0] OFS_BRAKE_SPD_TO = 8'h14;
  localparam logic [7:0] OFS_BRAKE_SPD_RAMP = 8'h18;
  localparam logic [7:0] OFS_ESTOP_TIME = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  // Config fields
  localparam int CFG_ENC = 0;
  localparam int CFG_FLY = 1;
  localparam int CFG_AUTO_ACK = 2;
  localparam int CFG_BRAKE_MODE = 3;
  localparam int CFG_ESTOP_BEH = 5;
  localparam int CFG_FB_ACTION = 7;
  localparam int CFG_FB_TYPE = 8;
  // Reset values
  localparam logic [15:0] CONFIG_RST = 16'h0000;
  localparam logic [15:0] COAST_RST = 16'h03E8;
  localparam logic [15:0] RESTART_RST = 16'h03E8;
  localparam logic [15:0] BRAKE_DELAY_RST = 16'h0000;
  localparam logic [15:0] ZERO_SPEED_RST = 16'h000A;
  localparam logic [15:0] BRAKE_SPD_RST = 16'h0032;
  localparam logic [15:0] ESTOP_TIME_RST = 16'h07D0;
  // ****************************************
  // Encodings
  // ****************************************
  localparam logic [1:0] BRAKE_NONE = 2'h0;
  localparam logic [1:0] BRAKE_DELAYED = 2'h1;
  localparam logic [1:0] BRAKE_SPEED = 2'h2;
  localparam logic [1:0] ESTOP_IMMEDIATE = 2'h0;
  localparam logic [1:0] ESTOP_RAMP = 2'h1;
  localparam logic [1:0] ESTOP_TIMED = 2'h2;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_STOPPING = 2'b01,
    ST_PRE_BRAKE = 2'b11,
    ST_OFF = 2'b10
  } seq_state_t;
endpackage

// File: timer_if.sv
interface timer_if #(parameter int W = 16);
  logic clear;
  logic [W-1:0] elapsed;
  modport ctrl (output clear, input elapsed);
  modport tmr (input clear, output elapsed);
endinterface

// File: ms_elapsed_timer.sv
module ms_elapsed_timer #(
  parameter int CYC_PER_MS = torque_off_pkg::CYC_PER_MS,
  parameter int W = 16
) (
  input wire logic core_clk,
  input wire logic srst,
  timer_if.tmr tif
);
  localparam int DW = $clog2(CYC_PER_MS);
  if (CYC_PER_MS < 2 || W < 2) begin : g_chk
    $error("ms_elapsed_timer: bad parameters");
  end
  typedef struct packed {
    logic [DW-1:0] div;
    logic [W-1:0] el;
  } tmr_state_t;
  tmr_state_t q, d;
  // ****************************************
  // Millisecond divider and saturating count
  // ****************************************
  always_comb begin
    d = q;
    if (tif.clear) begin
      d.div = '0;
      d.el = '0;
    end else if (q.div == DW'(CYC_PER_MS - 1)) begin
      d.div = '0;
      if (q.el != '1) begin
        d.el = q.el + 1'b1;
      end
    end else begin
      d.div = q.div + 1'b1;
    end
  end
  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end
  assign tif.elapsed = q.el;
endmodule // ms_elapsed_timer

// File: torque_off_brake_sequencer.sv
module torque_off_brake_sequencer #(
  parameter int CYC_PER_MS = torque_off_pkg::CYC_PER_MS
) (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic torque_off_req_a,
  input wire logic torque_off_req_b,
  input wire logic estop_req_a,
  input wire logic estop_req_b,
  input wire logic cstop_req_a,
  input wire logic cstop_req_b,
  input wire logic bus_torque_off_req,
  input wire logic bus_estop_req,
  input wire logic bus_cstop_req,
  input wire logic bus_passivated,
  input wire logic diag_fault,
  input wire logic limited_speed_trip,
  input wire logic ramp_stop_done,
  input wire logic ack_button_input,
  input wire logic [15:0] speed_abs,
  input wire logic relay_feedback,
  output logic torque_off_cmd,
  output logic brake_output,
  output logic torque_off_indication,
  output logic torque_off_done_indication,
  output logic emergency_stop_indication,
  output logic emergency_stop_done_indication,
  output logic stop_done_indication,
  output logic brake_fault
);
  if (CYC_PER_MS < 2) begin : g_chk
    $error("torque_off_brake_sequencer: CYC_PER_MS too small");
  end

  typedef struct packed {
    torque_off_pkg::seq_state_t st;
    logic to_cmd;
    logic brake;
    logic estop;
    logic cstop;
    logic done;
    logic ack_prev;
    logic fb_fault;
    logic [3:0] fb_cnt;
    logic [15:0] cfg;
    logic [15:0] coast;
    logic [15:0] restart;
    logic [15:0] bdly;
    logic [15:0] zero;
    logic [15:0] spd_to;
    logic [15:0] spd_ramp;
    logic [15:0] etime;
    logic [31:0] rdata;
  } seq_t;

  seq_t q, d;
  timer_if #(.W(16)) tif ();

  ms_elapsed_timer #(.CYC_PER_MS(CYC_PER_MS), .W(16)) u_timer (
    .core_clk(core_clk),
    .srst(srst),
    .tif(tif.tmr)
  );

  // ****************************************
  // Configuration decode
  // ****************************************
  logic enc;
  logic fly;
  logic auto_ack;
  logic [1:0] bmode;
  logic [1:0] ebeh;
  logic fb_act;
  logic signed [15:0] bd;
  logic bd_neg;
  logic bd_pos;
  logic [15:0] bd_mag;
  logic [15:0] el;
  logic slow;
  logic gate;
  logic pre_first;
  logic to_req;
  logic es_src;
  logic cs_src;
  logic ack_rise;
  logic fb_bad;
  logic fast_stop;
  logic spd_hit;
  logic done_hit;

  assign enc = q.cfg[torque_off_pkg::CFG_ENC];
  assign fly = q.cfg[torque_off_pkg::CFG_FLY];
  assign auto_ack = q.cfg[torque_off_pkg::CFG_AUTO_ACK];
  assign bmode = q.cfg[torque_off_pkg::CFG_BRAKE_MODE +: 2];
  assign ebeh = q.cfg[torque_off_pkg::CFG_ESTOP_BEH +: 2];
  assign fb_act = q.cfg[torque_off_pkg::CFG_FB_ACTION];
  assign bd = q.bdly;
  assign bd_neg = bd[15];
  assign bd_pos = !bd[15] && (bd != 16'sh0000);
  assign bd_mag = bd_neg ? 16'(-bd) : q.bdly;
  assign el = tif.elapsed;
  assign slow = speed_abs < q.zero;
  assign pre_first = (bmode == torque_off_pkg::BRAKE_DELAYED) && bd_neg;
  assign ack_rise = ack_button_input && !q.ack_prev;

  // ****************************************
  // Request sources
  // ****************************************
  assign to_req = torque_off_req_a | torque_off_req_b | bus_torque_off_req
    | diag_fault
    | (q.fb_fault & fb_bad & !fb_act);
  assign es_src = estop_req_a | estop_req_b | bus_estop_req
    | diag_fault | bus_passivated
    | limited_speed_trip
    | (q.fb_fault & fb_bad & fb_act);
  assign cs_src = cstop_req_a | cstop_req_b | bus_cstop_req;
  // Speed limit takes priority over stop completion
  assign fast_stop = to_req || (es_src && ebeh == torque_off_pkg::ESTOP_IMMEDIATE);
  assign spd_hit = q.st == torque_off_pkg::ST_STOPPING && bmode == torque_off_pkg::BRAKE_SPEED
    && speed_abs < q.spd_ramp;
  assign done_hit = q.st == torque_off_pkg::ST_STOPPING && (ramp_stop_done
    || (q.estop && ebeh == torque_off_pkg::ESTOP_TIMED && el >= q.etime));

  // ****************************************
  // Acknowledgement gate
  // ****************************************
  always_comb begin
    if (enc) begin
      gate = slow && (!fly || el >= q.restart);
    end else if (fly) begin
      gate = el >= q.restart;
    end else begin
      gate = el >= q.coast;
    end
  end

  assign fb_bad = relay_feedback != (q.brake ^ q.cfg[torque_off_pkg::CFG_FB_TYPE]);

  function automatic logic [31:0] reg_read(input seq_t s, input logic [7:0] a, input logic g);
    logic [31:0] r;
    r = '0;
    case (a)
      torque_off_pkg::OFS_CONFIG: r = {16'h0000, s.cfg};
      torque_off_pkg::OFS_COAST: r = {16'h0000, s.coast};
      torque_off_pkg::OFS_RESTART: r = {16'h0000, s.restart};
      torque_off_pkg::OFS_BRAKE_DELAY: r = {16'h0000, s.bdly};
      torque_off_pkg::OFS_ZERO_SPEED: r = {16'h0000, s.zero};
      torque_off_pkg::OFS_BRAKE_SPD_TO: r = {16'h0000, s.spd_to};
      torque_off_pkg::OFS_BRAKE_SPD_RAMP: r = {16'h0000, s.spd_ramp};
      torque_off_pkg::OFS_ESTOP_TIME: r = {16'h0000, s.etime};
      torque_off_pkg::OFS_STATUS: r = {23'h000000, g, s.done, s.fb_fault, s.cstop, s.estop,
                                       s.brake, s.to_cmd, s.st};
      default: r = '0;
    endcase
    return r;
  endfunction

  // ****************************************
  // Sequencer
  // ****************************************
  always_comb begin
    d = q;
    d.ack_prev = ack_button_input;
    d.rdata = reg_rd ? reg_read(q, reg_addr, gate) : '0;
    if (reg_wr) begin
      case (reg_addr)
        torque_off_pkg::OFS_CONFIG: d.cfg = reg_wdata[15:0];
        torque_off_pkg::OFS_COAST: d.coast = reg_wdata[15:0];
        torque_off_pkg::OFS_RESTART: d.restart = reg_wdata[15:0];
        torque_off_pkg::OFS_BRAKE_DELAY: d.bdly = reg_wdata[15:0];
        torque_off_pkg::OFS_ZERO_SPEED: d.zero = reg_wdata[15:0];
        torque_off_pkg::OFS_BRAKE_SPD_TO: d.spd_to = reg_wdata[15:0];
        torque_off_pkg::OFS_BRAKE_SPD_RAMP: d.spd_ramp = reg_wdata[15:0];
        torque_off_pkg::OFS_ESTOP_TIME: d.etime = reg_wdata[15:0];
        default: d.cfg = q.cfg;
      endcase
    end
    // Relay feedback supervision
    if (fb_bad) begin
      if (q.fb_cnt == torque_off_pkg::FB_CHECK_CYC) begin
        d.fb_fault = 1'b1;
      end else begin
        d.fb_cnt = q.fb_cnt + 1'b1;
      end
    end else begin
      d.fb_cnt = '0;
    end
    if (es_src) begin
      d.estop = 1'b1;
    end
    if (cs_src) begin
      d.cstop = 1'b1;
    end
    case (q.st)
      torque_off_pkg::ST_RUN, torque_off_pkg::ST_STOPPING: begin
        if (fast_stop || (done_hit && !spd_hit)) begin
          if (pre_first) begin
            d.st = torque_off_pkg::ST_PRE_BRAKE;
            d.brake = 1'b1;
          end else begin
            d.st = torque_off_pkg::ST_OFF;
            d.to_cmd = 1'b1;
            if (bmode == torque_off_pkg::BRAKE_DELAYED && !bd_pos) begin
              d.brake = 1'b1;
            end
          end
        end else if (spd_hit) begin
          d.brake = 1'b1;
          if (bd_neg) begin
            d.st = torque_off_pkg::ST_PRE_BRAKE;
          end else begin
            d.st = torque_off_pkg::ST_OFF;
            d.to_cmd = 1'b1;
          end
        end else if (q.st == torque_off_pkg::ST_RUN && (es_src || cs_src)) begin
          d.st = torque_off_pkg::ST_STOPPING;
        end
      end
      torque_off_pkg::ST_PRE_BRAKE: begin
        if (el >= bd_mag) begin
          d.st = torque_off_pkg::ST_OFF;
          d.to_cmd = 1'b1;
        end
      end
      torque_off_pkg::ST_OFF: begin
        if (bmode == torque_off_pkg::BRAKE_DELAYED && !q.brake
            && ((bd_pos && el >= bd_mag) || (enc && slow))) begin
          d.brake = 1'b1;
        end
        if (bmode == torque_off_pkg::BRAKE_SPEED && enc && speed_abs < q.spd_to) begin
          d.brake = 1'b1;
        end
        if (!to_req && !es_src && !cs_src && !fb_bad && gate && (auto_ack || ack_rise)) begin
          d.st = torque_off_pkg::ST_RUN;
          d.to_cmd = 1'b0;
          d.brake = 1'b0;
          d.estop = 1'b0;
          d.cstop = 1'b0;
          d.fb_fault = 1'b0;
        end
      end
      default: begin
        d.st = torque_off_pkg::ST_OFF;
        d.to_cmd = 1'b1;
      end
    endcase
    d.done = (d.st == torque_off_pkg::ST_OFF) && gate;
  end

  assign tif.clear = d.st != q.st;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      q <= '0;
      q.cfg <= torque_off_pkg::CONFIG_RST;
      q.coast <= torque_off_pkg::COAST_RST;
      q.restart <= torque_off_pkg::RESTART_RST;
      q.bdly <= torque_off_pkg::BRAKE_DELAY_RST;
      q.zero <= torque_off_pkg::ZERO_SPEED_RST;
      q.spd_to <= torque_off_pkg::BRAKE_SPD_RST;
      q.spd_ramp <= torque_off_pkg::BRAKE_SPD_RST;
      q.etime <= torque_off_pkg::ESTOP_TIME_RST;
    end else begin
      q <= d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign reg_rdata = q.rdata;
  assign torque_off_cmd = q.to_cmd;
  assign brake_output = q.brake;
  assign torque_off_indication = q.to_cmd;
  assign torque_off_done_indication = q.done;
  assign emergency_stop_indication = q.estop;
  assign emergency_stop_done_indication = q.estop & q.done;
  assign stop_done_indication = q.done;
  assign brake_fault = q.fb_fault;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (srst);

  a_to_request_now: assert property (
    torque_off_req_a && q.st == torque_off_pkg::ST_RUN && !pre_first |=> torque_off_cmd)
    else $error("torque-off not asserted after request");
  a_diag_raises_to: assert property (
    diag_fault && q.st != torque_off_pkg::ST_PRE_BRAKE && !pre_first ##1 !reg_wr[*2] |-> torque_off_cmd)
    else $error("diagnostic fault did not raise torque-off");
  a_indication_tracks: assert property (
    $changed(torque_off_cmd) |-> $changed(torque_off_indication) && torque_off_indication == torque_off_cmd)
    else $error("indication does not follow torque-off");
  a_ack_gated: assert property (
    $fell(torque_off_cmd) && !$past(enc) && !$past(fly) |-> $past(el) >= $past(q.coast))
    else $error("released before coast time");
  a_fly_gated: assert property (
    $fell(torque_off_cmd) && $past(fly) |-> $past(el) >= $past(q.restart))
    else $error("released before restart delay");
  a_enc_gated: assert property (
    $fell(torque_off_cmd) && $past(enc) |-> $past(speed_abs) < $past(q.zero))
    else $error("released above zero speed");
  a_latched_req: assert property (
    torque_off_cmd && to_req |=> torque_off_cmd)
    else $error("torque-off dropped while requested");
  a_brake_with_to: assert property (
    brake_output && !torque_off_cmd |-> q.st == torque_off_pkg::ST_PRE_BRAKE)
    else $error("brake active without torque-off path");
  a_zero_delay: assert property (
    $rose(torque_off_cmd) && bmode == torque_off_pkg::BRAKE_DELAYED && bd == 16'sh0000 |-> brake_output)
    else $error("zero delay brake not simultaneous");
  a_pos_delay: assert property (
    $rose(torque_off_cmd) && bmode == torque_off_pkg::BRAKE_DELAYED && bd_pos && !$past(q.brake) |-> !brake_output)
    else $error("brake before positive delay");
  a_neg_delay: assert property (
    $rose(brake_output) && pre_first && $past(q.st) != torque_off_pkg::ST_OFF |-> !torque_off_cmd)
    else $error("torque-off before brake on negative delay");
  a_estop_sources: assert property (
    diag_fault || bus_passivated || limited_speed_trip |=> emergency_stop_indication)
    else $error("emergency stop not raised");
  a_estop_immediate: assert property (
    estop_req_a && q.st == torque_off_pkg::ST_RUN && ebeh == torque_off_pkg::ESTOP_IMMEDIATE
    && !pre_first |=> torque_off_cmd)
    else $error("immediate emergency stop missed");
  a_ramp_done_to: assert property (
    q.st == torque_off_pkg::ST_STOPPING && ramp_stop_done |=> torque_off_cmd || brake_output)
    else $error("stop completion did not assert torque-off");
  a_fb_reaction: assert property (
    fb_bad && q.fb_cnt == torque_off_pkg::FB_CHECK_CYC |=> brake_fault)
    else $error("feedback fault not flagged");
endmodule // torque_off_brake_sequencer

// File: drive_brake_model.sv
module drive_brake_model (
  input wire logic core_clk,
  input wire logic srst,
  input wire logic brake_output,
  input wire logic fb_inverted,
  input wire logic fb_broken,
  input wire logic [15:0] speed_set,
  output logic relay_feedback,
  output logic [15:0] speed_abs
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Relay contact and speed sensor
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      relay_feedback <= fb_inverted;
      speed_abs <= 16'h0000;
    end else begin
      relay_feedback <= (brake_output ^ fb_inverted) ^ fb_broken;
      speed_abs <= speed_set;
    end
  end
endmodule // drive_brake_model

// File: torque_off_brake_sequencer_bench.sv
module torque_off_brake_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0000_0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [11:0] src = 12'h000;
  logic ramp_stop_done = 1'b0;
  logic ack = 1'b0;
  logic [15:0] speed = 16'h0000;
  logic fb_broken = 1'b0;
  logic fb_inv = 1'b0;
  logic relay_feedback, torque_off_cmd, brake_output, torque_off_indication, torque_off_done_indication;
  logic emergency_stop_indication, emergency_stop_done_indication, stop_done_indication, brake_fault;
  logic [15:0] speed_abs;
  int err_count = 0;
  int n_tests = 0;
  // ****************************************
  // Instances
  // ****************************************
  torque_off_brake_sequencer #(.CYC_PER_MS(4)) u_torque_off_brake_sequencer (
    .core_clk(core_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .torque_off_req_a(src[0]), .torque_off_req_b(src[1]),
    .bus_torque_off_req(src[2]), .estop_req_a(src[3]), .estop_req_b(src[4]), .bus_estop_req(src[5]),
    .bus_passivated(src[6]), .diag_fault(src[7]), .limited_speed_trip(src[8]), .cstop_req_a(src[9]),
    .cstop_req_b(src[10]), .bus_cstop_req(src[11]), .ramp_stop_done(ramp_stop_done),
    .ack_button_input(ack), .speed_abs(speed_abs), .relay_feedback(relay_feedback),
    .torque_off_cmd(torque_off_cmd), .brake_output(brake_output), .torque_off_indication(torque_off_indication),
    .torque_off_done_indication(torque_off_done_indication), .emergency_stop_indication(emergency_stop_indication),
    .emergency_stop_done_indication(emergency_stop_done_indication), .stop_done_indication(stop_done_indication),
    .brake_fault(brake_fault));
  drive_brake_model u_drive_brake_model (
    .core_clk(core_clk), .srst(srst), .brake_output(brake_output), .fb_inverted(fb_inv), .fb_broken(fb_broken),
    .speed_set(speed), .relay_feedback(relay_feedback), .speed_abs(speed_abs));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  // ****************************************
  // Tasks
  // ****************************************
  task automatic finish_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      err_count++;
      $display("[ERR] %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg_rdata", e, reg_rdata);
  endtask
  task automatic req(input logic [11:0] s);
    @(posedge core_clk);
    src <= s;
  endtask
  task automatic spd(input logic [15:0] v);
    @(posedge core_clk);
    speed <= v;
  endtask
  task automatic ack_pulse();
    @(posedge core_clk);
    ack <= 1'b1;
    @(posedge core_clk);
    ack <= 1'b0;
  endtask
  function automatic logic sel(input int w);
    case (w)
      0: return torque_off_cmd;
      1: return brake_output;
      default: return brake_fault;
    endcase
  endfunction
  task automatic wait_for(input int w, input logic lvl, input int lim, input string n);
    int k;
    for (k = 0; k < lim; k++) begin
      step(1);
      if (sel(w) === lvl) break;
    end
    n_tests++;
    if (k == lim) begin
      err_count++;
      $display("[ERR] %s expected %b seen %b", n, lvl, sel(w));
      finish_test();
    end
  endtask
  task automatic release_all();
    @(posedge core_clk);
    src <= 12'h000;
    ramp_stop_done <= 1'b0;
    speed <= 16'h0000;
    fb_broken <= 1'b0;
    step(20);
    if (torque_off_cmd === 1'b1) chk("stop_done_indication", 1, stop_done_indication);
    if (torque_off_cmd === 1'b1) chk("torque_off_done_indication", 1, torque_off_done_indication);
    ack_pulse();
    wait_for(0, 1'b0, 8, "torque_off_cmd");
    wait_for(1, 1'b0, 8, "brake_output");
    step(1);
    chk("torque_off_indication", 0, torque_off_indication);
    chk("brake_fault", 0, brake_fault);
  endtask
  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    rd(torque_off_pkg::OFS_CONFIG, 32'h0000_0000);
    rd(torque_off_pkg::OFS_COAST, 32'h0000_03E8);
    rd(torque_off_pkg::OFS_RESTART, 32'h0000_03E8);
    rd(torque_off_pkg::OFS_BRAKE_DELAY, 32'h0000_0000);
    rd(torque_off_pkg::OFS_ZERO_SPEED, 32'h0000_000A);
    rd(torque_off_pkg::OFS_BRAKE_SPD_TO, 32'h0000_0032);
    rd(torque_off_pkg::OFS_BRAKE_SPD_RAMP, 32'h0000_0032);
    rd(torque_off_pkg::OFS_ESTOP_TIME, 32'h0000_07D0);
    wr(torque_off_pkg::OFS_STATUS, 32'h0000_00FF);
    rd(torque_off_pkg::OFS_STATUS, 32'h0000_0000);
    rd(8'h24, 32'h0000_0000);
    wr(torque_off_pkg::OFS_COAST, 32'hFFFF_0003);
    rd(torque_off_pkg::OFS_COAST, 32'h0000_0003);
    // Coast gate and latch
    wr(torque_off_pkg::OFS_CONFIG, 32'h0000_0000);
    req(12'h001);
    step(1);
    chk("torque_off_cmd", 1, torque_off_cmd);
    step(1);
    chk("torque_off_indication", 1, torque_off_indication);
    req(12'h000);
    ack_pulse();
    step(2);
    chk("torque_off_cmd", 1, torque_off_cmd);
    release_all();
    // Fly-start gate shorter than coast
    wr(torque_off_pkg::OFS_CONFIG, 32'h0000_0002);
    wr(torque_off_pkg::OFS_RESTART, 32'h0000_0002);
    wr(torque_off_pkg::OFS_COAST, 32'h0000_0064);
    req(12'h002);
    step(1);
    chk("torque_off_cmd", 1, torque_off_cmd);
    req(12'h000);
    ack_pulse();
    step(2);
    chk("torque_off_cmd", 1, torque_off_cmd);
    release_all();
    wr(torque_off_pkg::OFS_COAST, 32'h0000_0003);
    // Encoder gate with automatic acknowledge
    wr(torque_off_pkg::OFS_CONFIG, 32'h0000_0005);
    spd(16'h0064);
    req(12'h004);
    step(1);
    chk("torque_off_cmd", 1, torque_off_cmd);
    req(12'h000);
    ack_pulse();
    step(24);
    chk("torque_off_cmd", 1, torque_off_cmd);
    spd(16'h0005);
    wait_for(0, 1'b0, 10, "torque_off_cmd");
    release_all();
    // Delayed brake, positive delay
    wr(torque_off_pkg::OFS_CONFIG, 32'h0000_0008);
    wr(torque_off_pkg::OFS_BRAKE_DELAY, 32'h0000_0002);
    req(12'h001);
    step(1);
    chk("brake_output", 0, brake_output);
    step(4);
    chk("brake_output", 0, brake_output);
    wait_for(1, 1'b1, 12, "brake_output");
    chk("torque_off_cmd", 1, torque_off_cmd);
    release_all();
    // Zero delay with inverted feedback
    wr(torque_off_pkg::OFS_CONFIG, 32'h0000_0108);
    fb_inv <= 1'b1;
    wr(torque_off_pkg::OFS_BRAKE_DELAY, 32'h0000_0000);
    req(12'h001);
    step(1);
    chk("torque_off_cmd", 1, torque_off_cmd);
    chk("brake_output", 1, brake_output);
    release_all();
    fb_inv <= 1'b0;
    // Negative delay
    wr(torque_off_pkg::OFS_CONFIG, 32'h0000_0008);
    wr(torque_off_pkg::OFS_BRAKE_DELAY, 32'h0000_FFFE);
    req(12'h001);
    step(1);
    chk("brake_output", 1, brake_output);
    step(4);
    chk("torque_off_cmd", 0, torque_off_cmd);
    wait_for(0, 1'b1, 12, "torque_off_cmd");
    release_all();
    // Early brake below zero speed
    wr(torque_off_pkg::OFS_CONFIG, 32'h0000_0009);
    wr(torque_off_pkg::OFS_BRAKE_DELAY, 32'h0000_0008);
    spd(16'h0064);
    req(12'h001);
    step(3);
    chk("brake_output", 0, brake_output);
    spd(16'h0005);
    wait_for(1, 1'b1, 6, "brake_output");
    release_all();
    // Speed-limit brake on plain torque-off
    wr(torque_off_pkg::OFS_CONFIG, 32'h0000_0011);
    wr(torque_off_pkg::OFS_BRAKE_DELAY, 32'h0000_0004);
    spd(16'h0064);
    req(12'h001);
    step(5);
    chk("brake_output", 0, brake_output);
    spd(16'h0028);
    wait_for(1, 1'b1, 4, "brake_output");
    release_all();
    // Relay feedback failure
    wr(torque_off_pkg::OFS_CONFIG, 32'h0000_0088);
    wr(torque_off_pkg::OFS_BRAKE_DELAY, 32'h0000_0000);
    fb_broken <= 1'b1;
    wait_for(2, 1'b1, 24, "brake_fault");
    step(2);
    chk("emergency_stop_indication", 1, emergency_stop_indication);
    ack_pulse();
    step(2);
    chk("brake_fault", 1, brake_fault);
    release_all();
    // Every source: nine immediate ones, then the three stop requests that wait for ramp_stop_done
    wr(torque_off_pkg::OFS_CONFIG, 32'h0000_0000);
    for (int i = 0; i < 9; i++) begin
      req(12'h001 << i);
      step(1);
      chk("torque_off_cmd", 1, torque_off_cmd);
      step(1);
      if (i > 2) chk("emergency_stop_indication", 1, emergency_stop_indication);
      release_all();
    end
    for (int i = 9; i < 12; i++) begin
      req(12'h001 << i);
      step(3);
      chk("torque_off_cmd", 0, torque_off_cmd);
      ramp_stop_done <= 1'b1;
      wait_for(0, 1'b1, 4, "torque_off_cmd");
      release_all();
    end
    // Ramp and time-monitored emergency stop
    wr(torque_off_pkg::OFS_ESTOP_TIME, 32'h0000_0002);
    for (int b = 1; b < 3; b++) begin
      wr(torque_off_pkg::OFS_CONFIG, 32'(b) << 5);
      req(12'h008);
      step(3);
      chk("torque_off_cmd", 0, torque_off_cmd);
      if (b == 1) ramp_stop_done <= 1'b1;
      wait_for(0, 1'b1, 12, "torque_off_cmd");
      step(16);
      chk("emergency_stop_done_indication", 1, emergency_stop_done_indication);
      release_all();
    end
    // Speed-limit brake, negative delay, ramp stop
    wr(torque_off_pkg::OFS_CONFIG, 32'h0000_0031);
    wr(torque_off_pkg::OFS_BRAKE_DELAY, 32'h0000_FFFC);
    spd(16'h0028);
    req(12'h008);
    ramp_stop_done <= 1'b1;
    wait_for(1, 1'b1, 6, "brake_output");
    chk("torque_off_cmd", 0, torque_off_cmd);
    wait_for(0, 1'b1, 20, "torque_off_cmd");
    release_all();
    finish_test();
  end
endmodule // torque_off_brake_sequencer_bench
